/* File: shic_standby_ctrl.sv */
`timescale 1ns/1ps

// Overview of operation
// R01: Reset in halt acts as normal reset
// R02: Timer M runs unless subclock source, no-sub
// R03: Watch timer runs only on divided main clock; code also runs it whenever subclock_used is set
// R04: Watchdog runs unless internal oscillator, no-sub
// R05: CRC runs unless its input is written
// R06: Port pins hold state during halt
// R07: CPU state and RAM preserved in halt
// R08: Idle-1 entry: select 00, stop bit written
// R09: Idle-1 keeps oscillators, PLL, flash; gates CPU
// R10: Idle-1 keeps subclock/external-clock peripherals, RAM
// R11: Idle-1 exit takes no stabilisation wait
// R12: Software puts five NOPs after entry store
// R13: Pending unmasked interrupt ends idle-1 at once
// R14: NMI, watchdog, pin, peripheral irqs, reset wake
// R15: Every release returns to normal mode
// R16: Halt instruction enters halt; only CPU stops; code can also stop timer M, watch timer, watchdog and CRC (R02-R05)
// R17: Wake acknowledged only above current priority
// R18: DMA, timers P/Q, serial, converters run in halt
module shic_standby_ctrl
  import shic_pkg::*;
(
  input  wire logic                       clk,               // 200 MHz clock
  input  wire logic                       srst,              // Sync reset, high
  input  wire logic                       any_reset,         // Pin/watchdog/LOW_VOLTAGE_DETECTOR/monitor reset
  input  wire logic                       halt_exec,         // Halt instruction executed
  input  wire logic                       psc_write,         // Store to power_save_ctrl_reg
  input  wire logic                       stop_request_bit,  // Stop bit in that store
  input  wire logic                       msel_write,        // Store to power_mode_select_reg
  input  wire logic                       mode_select_hi,    // Select bit 1
  input  wire logic                       mode_select_lo,    // Select bit 0
  input  wire logic                       nmi_pin,           // Non-maskable pin request
  input  wire logic                       watchdog_irq,      // Watchdog request
  input  wire logic [SHIC_NUM_PERIPH-1:0] ext_pin_irq,       // Pin irqs, first..last
  input  wire logic [SHIC_NUM_PERIPH-1:0] ext_pin_mask,      // High masks pin irq
  input  wire logic                       periph_irq,        // Unmasked internal request
  input  wire logic                       periph_irq_idle,   // Source runs in idle-1
  input  wire logic [SHIC_PRIO_W-1:0]     irq_prio,          // Priority of waking request
  input  wire logic [SHIC_PRIO_W-1:0]     isr_prio,          // Priority being serviced
  input  wire logic                       in_isr,            // Entered inside a handler
  input  wire logic                       subclock_used,     // Subclock oscillator in use
  input  wire logic [1:0]                 tmm_src,           // Timer M count source
  input  wire logic [1:0]                 watch_src,         // Watch timer count source
  input  wire logic [1:0]                 wdt_src,           // Watchdog count source
  input  wire logic                       crc_in_write,      // Write to crc_input_reg
  input  wire logic                       ext_clk_periph,    // Peripheral on external clock
  input  wire logic [7:0]                 port_drive,        // Port levels from CPU logic
  output shic_mode_t                      mode,              // Current mode
  output logic                            cpu_clk_en,        // CPU clock enable
  output logic                            osc_pll_en,        // Oscillators, PLL, flash
  output logic                            periph_clk_en,     // DMA, timers P/Q, serial etc
  output logic                            tmm_clk_en,        // Timer M enable
  output logic                            watch_clk_en,      // Watch timer enable
  output logic                            wdt_clk_en,        // Watchdog enable
  output logic                            crc_clk_en,        // CRC circuit enable
  output logic                            ext_clk_en,        // External/sub-clock peripherals
  output logic                            state_hold,        // Freeze CPU regs and RAM
  output logic                            stab_wait,         // Oscillation wait request
  output logic                            wake_ack,          // Wake request acknowledged
  output logic                            wake_pend,         // Wake request left pending
  output logic [7:0]                      port_out           // Held port levels
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode select register and wake decode

  logic [1:0]       msel;
  logic [1:0]       next_msel;
  shic_mode_t       next_mode;
  logic             next_wake_ack;
  logic             next_wake_pend;
  logic [7:0]       next_port_out;
  logic             wake;
  logic             prio_hi;

  function automatic logic pin_wake(input logic [SHIC_NUM_PERIPH-1:0] req,
                                    input logic [SHIC_NUM_PERIPH-1:0] msk);
    pin_wake = |(req & ~msk);
  endfunction

  // Internal requests from halted peripherals cannot arrive in idle-1
  always_comb
  begin
    wake = nmi_pin | watchdog_irq | pin_wake(ext_pin_irq, ext_pin_mask)
         | (periph_irq & ((mode != SHIC_IDLE_ONE_MODE) | periph_irq_idle)); // R14 R13
    // Both non-maskable sources outrank any handler being serviced
    prio_hi = !in_isr || nmi_pin || watchdog_irq || (irq_prio < isr_prio); // R17
  end

  always_comb
  begin
    next_msel = msel;
    if (msel_write)
    begin
      next_msel = {mode_select_hi, mode_select_lo};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  // A pending request still enters the mode for one cycle, then leaves it
  always_comb
  begin
    next_mode      = mode;
    next_wake_ack  = 1'b0;
    next_wake_pend = 1'b0;
    unique case (mode)
      SHIC_NORMAL:
      begin
        if (halt_exec)
        begin
          next_mode = SHIC_HALT; // R16
        end
        else if (psc_write && stop_request_bit && msel == SHIC_PSM_IDLE_ONE_MODE)
        begin
          next_mode = SHIC_IDLE_ONE_MODE; // R08
        end
      end
      SHIC_HALT, SHIC_IDLE_ONE_MODE:
      begin
        if (wake)
        begin
          next_mode      = SHIC_NORMAL; // R15 R13
          next_wake_ack  = prio_hi; // R17
          next_wake_pend = !prio_hi; // R17
        end
      end
      default:
      begin
        next_mode = SHIC_NORMAL;
      end
    endcase
    if (any_reset)
    begin
      next_mode      = SHIC_NORMAL; // R01 R14
      next_wake_ack  = 1'b0;
      next_wake_pend = 1'b0;
    end
  end

  always_comb
  begin
    next_port_out = port_out;
    if (mode == SHIC_NORMAL)
    begin
      next_port_out = port_drive; // R06
    end
  end

  // Same reset path whatever mode was active
  always_ff @(posedge clk)
  begin
    if (srst || any_reset) // R01
    begin
      mode      <= SHIC_NORMAL;
      msel      <= SHIC_PSM_RESET;
      wake_ack  <= 1'b0;
      wake_pend <= 1'b0;
      port_out  <= 8'h00;
    end
    else
    begin
      mode      <= next_mode;
      msel      <= next_msel;
      wake_ack  <= next_wake_ack;
      wake_pend <= next_wake_pend;
      port_out  <= next_port_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables

  logic tmm_halt;
  logic watch_halt;
  logic wdt_halt;
  logic tmm_idle;
  logic wdt_idle;

  always_comb
  begin
    tmm_halt   = subclock_used || (tmm_src != SHIC_SRC_SUB); // R02
    watch_halt = subclock_used || (watch_src == SHIC_SRC_BRG); // R03
    wdt_halt   = subclock_used || (wdt_src != SHIC_SRC_INTOSC); // R04
    tmm_idle   = subclock_used && (tmm_src == SHIC_SRC_SUB); // R10
    wdt_idle   = subclock_used && (wdt_src == SHIC_SRC_SUB); // R10
  end

  shic_clk_gate u_cpu
  (
    .mode     (mode),
    .halt_run (1'b0),
    .idle_run (1'b0),
    .run_en   (cpu_clk_en)
  ); // R09 R16

  shic_clk_gate u_periph
  (
    .mode     (mode),
    .halt_run (1'b1),
    .idle_run (1'b0),
    .run_en   (periph_clk_en)
  ); // R18 R09

  shic_clk_gate u_tmm
  (
    .mode     (mode),
    .halt_run (tmm_halt),
    .idle_run (tmm_idle),
    .run_en   (tmm_clk_en)
  ); // R02

  shic_clk_gate u_watch
  (
    .mode     (mode),
    .halt_run (watch_halt),
    .idle_run (watch_halt),
    .run_en   (watch_clk_en)
  ); // R03

  shic_clk_gate u_wdt
  (
    .mode     (mode),
    .halt_run (wdt_halt),
    .idle_run (wdt_idle),
    .run_en   (wdt_clk_en)
  ); // R04

  // Feeding the CRC needs the CPU, so a write while halted is not served
  shic_clk_gate u_crc
  (
    .mode     (mode),
    .halt_run (!crc_in_write),
    .idle_run (1'b0),
    .run_en   (crc_clk_en)
  ); // R05

  shic_clk_gate u_ext
  (
    .mode     (mode),
    .halt_run (1'b1),
    .idle_run (ext_clk_periph || subclock_used),
    .run_en   (ext_clk_en)
  ); // R10

  assign osc_pll_en = 1'b1; // R09
  assign stab_wait  = 1'b0; // R11
  assign state_hold = (mode != SHIC_NORMAL); // R07 R10

endmodule

/* File: shic_pkg.sv */
package shic_pkg;

  typedef enum logic [1:0]
  {
    SHIC_NORMAL = 2'b00,
    SHIC_HALT   = 2'b01,
    SHIC_IDLE_ONE_MODE  = 2'b10
  } shic_mode_t;

  // Power-mode select value that picks idle-1
  localparam logic [1:0] SHIC_PSM_IDLE_ONE_MODE    = 2'h0;
  localparam logic [1:0] SHIC_PSM_RESET    = 2'h0;
  localparam logic       SHIC_PRIO_RESET   = 1'h0;

  // Count-clock source codes, shared by the controller and the testbench
  localparam logic [1:0] SHIC_SRC_MAIN     = 2'h0;
  localparam logic [1:0] SHIC_SRC_SUB      = 2'h1;
  localparam logic [1:0] SHIC_SRC_INTOSC   = 2'h2;
  localparam logic [1:0] SHIC_SRC_BRG      = 2'h3;

  localparam int         SHIC_NUM_PERIPH   = 8;
  localparam int         SHIC_PRIO_W       = 3;
  localparam logic [2:0] SHIC_PRIO_NONE    = 3'h7;

endpackage

/* File: shic_clk_gate.sv */
`timescale 1ns/1ps

// Enable for one group of logic, per mode; combinational from mode/source.
module shic_clk_gate
  import shic_pkg::*;
(
  input  wire shic_mode_t mode,          // Current standby mode
  input  wire logic       halt_run,      // Group may run in halt
  input  wire logic       idle_run,      // Group may run in idle-1
  output logic            run_en         // Group clock enable
);

  always_comb
  begin
    unique case (mode)
      SHIC_NORMAL: run_en = 1'b1;
      SHIC_HALT:   run_en = halt_run;
      SHIC_IDLE_ONE_MODE:  run_en = idle_run;
      default:     run_en = 1'b0;
    endcase
  end

endmodule

/* File: shic_chk_properties.sv */
`timescale 1ns/1ps
module shic_chk
  import shic_pkg::*;
(
  input wire logic       clk,              // Clock
  input wire logic       srst,             // Reset
  input wire logic       any_reset,        // Chip reset
  input wire logic       halt_exec,        // Halt instr
  input wire logic       psc_write,        // Ctrl store
  input wire logic       stop_request_bit, // Stop bit
  input wire logic       msel_write,       // Select store
  input wire logic       mode_select_hi,   // Select hi
  input wire logic       mode_select_lo,   // Select lo
  input wire logic       nmi_pin,          // NMI
  input wire shic_mode_t mode,             // Mode
  input wire logic       cpu_clk_en,       // CPU run
  input wire logic       periph_clk_en,    // Periph run
  input wire logic       osc_pll_en,       // Osc run
  input wire logic       wake_ack,         // Ack
  input wire logic [7:0] port_out          // Ports
);
  logic [1:0] msel;
  wire        nrm = mode == SHIC_NORMAL;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Select register is internal, so mirror it here
  always_ff @(posedge clk)
    if (srst || any_reset)
      msel <= 2'h0;
    else if (msel_write)
      msel <= {mode_select_hi, mode_select_lo};
////////////////////////////////////////
  halt_entry_a: assert property (nrm && halt_exec && !any_reset |=> mode == SHIC_HALT)
    else $error("no halt entry");
  idle_entry_a: assert property (nrm && !halt_exec && !any_reset && psc_write &&
    stop_request_bit && msel == SHIC_PSM_IDLE_ONE_MODE |=> mode == SHIC_IDLE_ONE_MODE) else $error("no idle");
  reset_exit_a: assert property (any_reset |=> nrm && !wake_ack)
    else $error("reset missed");
  nmi_wake_a: assert property (!nrm && nmi_pin && !any_reset |=> nrm && wake_ack)
    else $error("no nmi wake");
  cpu_gate_a: assert property (cpu_clk_en == nrm) else $error("cpu clock");
  idle_gate_a: assert property (mode == SHIC_IDLE_ONE_MODE |-> !periph_clk_en) else $error("periph");
  halt_periph_a: assert property (mode == SHIC_HALT |-> periph_clk_en) else $error("stop");
  osc_run_a: assert property (osc_pll_en) else $error("osc off");
  port_hold_a: assert property (!nrm |=> nrm || $stable(port_out)) else $error("port");
  halt_c: cover property (mode == SHIC_HALT ##1 nrm);
  idle_c: cover property (mode == SHIC_IDLE_ONE_MODE ##1 nrm);
  ack_c: cover property (wake_ack);
endmodule
bind shic_standby_ctrl shic_chk shic_chk_inst (.*);

/* File: test_standby_halt_idle_control.sv */
`timescale 1ns/1ps
module test_standby_halt_idle_control
  import shic_pkg::*;
;
  logic clk = 0, srst = 1, any_reset = 0, halt_exec = 0, psc_write = 0, stop_request_bit = 0;
  logic msel_write = 0, mode_select_hi = 0, mode_select_lo = 0, nmi_pin = 0, watchdog_irq = 0;
  logic periph_irq = 0, periph_irq_idle = 0, in_isr = 0, subclock_used = 0, crc_in_write = 0;
  logic ext_clk_periph = 0, idl, a;
  logic [7:0] ext_pin_irq = '0, ext_pin_mask = '0, port_drive = '0, held, port_out;
  logic [2:0] irq_prio = '0, isr_prio = '0;
  logic [1:0] tmm_src = '0, watch_src = '0, wdt_src = '0;
  shic_mode_t mode;
  logic cpu_clk_en, osc_pll_en, periph_clk_en, tmm_clk_en, watch_clk_en, wdt_clk_en;
  logic crc_clk_en, ext_clk_en, state_hold, stab_wait, wake_ack, wake_pend;
  integer seed = 32'he86160ed, num_errors = 0, num_checks = 0, k;

  always #2.5 clk = ~clk;
  shic_standby_ctrl shic_standby_ctrl_inst (.*);

  // Timer enables in standby: timer M, watch timer, watchdog
  function logic [2:0] tim_en(input logic i, s, input logic [1:0] t, w, d);
    if (i)
      return {s & t == SHIC_SRC_SUB, s | w == SHIC_SRC_BRG, s & d == SHIC_SRC_SUB};
    return {s | t != SHIC_SRC_SUB, s | w == SHIC_SRC_BRG, s | d != SHIC_SRC_INTOSC};
  endfunction

  task cmp(input logic [9:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Select store and stop store back to back, or a halt
  task enter(input logic [1:0] sv);
    @(posedge clk);
    if (idl)
    begin
      msel_write <= 1'h1;
      {mode_select_hi, mode_select_lo} <= sv;
      @(posedge clk);
      msel_write <= 1'h0;
      {psc_write, stop_request_bit} <= 2'h3;
    end
    else
      halt_exec <= 1'h1;
    @(posedge clk);
    {halt_exec, psc_write, stop_request_bit} <= 3'h0;
  endtask

////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    cmp({mode, port_out}, 10'h0);
    repeat (24)
    begin
      idl = $random(seed);
      @(posedge clk);
      port_drive <= $random(seed);
      enter(SHIC_PSM_IDLE_ONE_MODE);
      held = port_drive;
      @(negedge clk);
      cmp(mode, idl ? SHIC_IDLE_ONE_MODE : SHIC_HALT);
      @(posedge clk);
      {subclock_used, tmm_src, watch_src, wdt_src, crc_in_write, ext_clk_periph} <= $random(seed);
      {port_drive, ext_pin_irq} <= $random(seed);
      ext_pin_mask <= 8'hff;
      periph_irq <= idl;
      {in_isr, irq_prio, isr_prio} <= $random(seed);
      k = $unsigned($random(seed)) % 4;
      @(negedge clk);
      cmp({tmm_clk_en, watch_clk_en, wdt_clk_en}, tim_en(idl, subclock_used, tmm_src, watch_src, wdt_src));
      cmp({cpu_clk_en, periph_clk_en, crc_clk_en, osc_pll_en, stab_wait, state_hold, ext_clk_en}, {1'h0, !idl, !idl & !crc_in_write, 3'h5, !idl | ext_clk_periph | subclock_used});
      @(posedge clk);
      {nmi_pin, periph_irq, watchdog_irq, periph_irq_idle} <= {k == 0, k == 2, k == 3, 1'h1};
      ext_pin_irq <= (k == 1) ? 8'h1 << port_drive[2:0] : 8'h0;
      ext_pin_mask <= 8'h0;
      @(negedge clk);
      cmp(mode, idl ? SHIC_IDLE_ONE_MODE : SHIC_HALT);
      cmp(port_out, held);
      @(posedge clk);
      {nmi_pin, periph_irq, watchdog_irq, periph_irq_idle, ext_pin_irq} <= 12'h0;
      a = k == 0 || k == 3 || !in_isr || irq_prio < isr_prio;
      @(negedge clk);
      cmp({mode, wake_ack, wake_pend}, {SHIC_NORMAL, a, !a});
    end
    idl = 1'h1;
    @(posedge clk);
    nmi_pin <= 1'h1;
    enter(SHIC_PSM_IDLE_ONE_MODE);
    @(negedge clk);
    cmp(mode, SHIC_IDLE_ONE_MODE);
    @(posedge clk);
    nmi_pin <= 1'h0;
    @(negedge clk);
    cmp(mode, SHIC_NORMAL);
    enter(2'h1);
    @(negedge clk);
    cmp(mode, SHIC_NORMAL);
    idl = 1'h0;
    enter(2'h0);
    @(posedge clk);
    any_reset <= 1'h1;
    @(posedge clk);
    any_reset <= 1'h0;
    @(negedge clk);
    cmp({mode, port_out}, 10'h0);
    conclude;
  end
endmodule
